// file: shared/apr_pkg.sv
`default_nettype none
package apr_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS      = 25;
  localparam int unsigned PPS_PERIOD_MS      = 1000;
  localparam int unsigned PPS_PERIOD_CYC     = PPS_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned PPS_TOL_US         = 1000;
  localparam int unsigned PPS_TOL_CYC        = PPS_TOL_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned TRIG_MIN_HIGH_NS   = 100;
  localparam int unsigned TRIG_MIN_HIGH_CYC  =
    (TRIG_MIN_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register bus
  localparam int unsigned ADDR_W             = 8;
  localparam int unsigned DATA_W             = 32;
  localparam logic [7:0]  BRD_CTRL_ADDR      = 8'h00;
  localparam logic [7:0]  PPS_CTRL_ADDR      = 8'h1C;
  localparam logic [7:0]  PPS_STAT_ADDR      = 8'h20;

  // board control fields
  localparam int unsigned ARM_BIT            = 0;
  localparam int unsigned SW_SYNC_BIT        = 1;
  localparam int unsigned FLUSH_BIT          = 2;
  localparam int unsigned ACQ_READY_BIT      = 3;

  // reference lock control fields
  localparam int unsigned TARGET_LSB         = 0;
  localparam int unsigned TARGET_W           = 20;
  localparam int unsigned LOCK_EN_BIT        = 20;
  localparam int unsigned WIDE_BIT           = 21;
  localparam int unsigned FALL_SEL_BIT       = 22;
  localparam int unsigned PULSE_LOCK_BIT     = 24;
  localparam int unsigned RATE_LOCK_BIT      = 25;
  localparam logic [19:0] TARGET_RST         = 20'h02000;

  // correction limits, in sample sets per second
  localparam logic [2:0]  CORR_NARROW        = 3'h1;
  localparam logic [2:0]  CORR_WIDE          = 3'h5;

  typedef enum logic [1:0] {
    L_OFF  = 2'b00,
    L_SEEK = 2'b01,
    L_MEAS = 2'b10,
    L_RUN  = 2'b11
  } apr_lock_t;

  typedef enum logic [1:0] {
    T_IDLE  = 2'b00,
    T_ARMED = 2'b01,
    T_WAIT  = 2'b10
  } apr_trig_t;

endpackage
`default_nettype wire

// file: hdl/apr_pin_edge.sv
`timescale 1ns/1ps
`default_nettype none
module apr_pin_edge
#(
  parameter int unsigned MIN_HIGH = 1
)
(
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic pin_in,
  input  wire logic invert_in,
  output logic      edge_out
);

  localparam int unsigned CW = $clog2(MIN_HIGH + 1);
  localparam logic [CW-1:0] MIN_C = CW'(MIN_HIGH);

  logic          meta_q;
  logic          sync_q;
  logic          prev_q;
  logic          lvl;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  initial
  begin
    if (MIN_HIGH < 1)
      $error("MIN_HIGH must be at least one");
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign lvl = sync_q ^ invert_in;

  // a level already high at reset is not an edge
  always_comb
  begin
    cnt_d = cnt_q;
    if (!lvl)
      cnt_d = '0;
    else if (!prev_q)
      cnt_d = CW'(1);
    else if (cnt_q != '0 && cnt_q != MIN_C)
      cnt_d = cnt_q + CW'(1);
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      prev_q   <= 1'b1;
      cnt_q    <= '0;
      edge_out <= 1'b0;
    end
    else
    begin
      prev_q   <= lvl;
      cnt_q    <= cnt_d;
      edge_out <= (cnt_d == MIN_C) && (cnt_q != MIN_C);
    end
  end

endmodule
`default_nettype wire

// file: hdl/apr_ctrl.sv
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - once both locks hold, count sample sets each second and compare with target
// - count equal to target means no correction that second
// - count one above target drops the next whole sample set
// - count one below target repeats the last acquired sample set
// - error beyond the allowed correction stops acquisition and relocks
// - wide-correction bit raises the allowed correction from one to five
// - with a good reference both locks rise within seconds, then acquisition runs
// - arm bit enters triggered mode, buffer cleared and held until trigger
// - external trigger is edge detected and must stay high 100 ns
// - after trigger buffer stays reset until next scan; arm self-clears there
// - acquisition-ready flag rises when the trigger sequence completes
// - further triggers are ignored until arm is set again
// - reference-pulse lock is inactive while arm is set
// - writing flush-on-sync high forces the arm bit to zero
// - scan alignment across boards is kept after a trigger
// - every board armed, initiator triggers, all start on next scan
// - lock enable clears buffer, halts acquisition, loops lock checks until both pass
// - target field is bits 0 to 19, default 0x2000
// - reference aligns to rising edge, or falling edge when selected
// - pulse lock means about one pulse per second; rate lock means count equals target (once running, rate lock stays set through in-limit corrections)
module apr_ctrl
  import apr_pkg::*;
#(
  parameter int unsigned ONE_SEC_CYC = PPS_PERIOD_CYC,
  parameter int unsigned TOL_CYC     = PPS_TOL_CYC
)
(
  input  wire logic              CLK_IN,
  input  wire logic              RST_B_IN,
  input  wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic [DATA_W-1:0] REG_WDATA_IN,
  input  wire logic              REG_WR_IN,
  input  wire logic              REG_RD_IN,
  output logic      [DATA_W-1:0] REG_RDATA_OUT,
  input  wire logic              EXTERNAL_TIMING_INPUT_IN,
  input  wire logic              SCAN_SET_IN,
  output logic                   STORE_SET_OUT,
  output logic                   REPEAT_SET_OUT,
  output logic                   BUF_CLEAR_OUT,
  output logic                   ACQ_READY_OUT,
  output logic                   PULSE_LOCKED_OUT,
  output logic                   RATE_LOCKED_OUT
);

  localparam int unsigned CYC_W = $clog2(ONE_SEC_CYC + TOL_CYC + 2);
  localparam logic [CYC_W-1:0] PER_MIN = CYC_W'(ONE_SEC_CYC - TOL_CYC);
  localparam logic [CYC_W-1:0] PER_MAX = CYC_W'(ONE_SEC_CYC + TOL_CYC);
  localparam int unsigned CNT_W = TARGET_W + 1;

  initial
  begin
    if (TOL_CYC == 0 || TOL_CYC >= ONE_SEC_CYC)
      $error("TOL_CYC must be above zero and below ONE_SEC_CYC");
  end

  // magnitude of a signed count error
  function automatic logic [CNT_W:0] abs_err(input logic signed [CNT_W:0] v);
    abs_err = v[CNT_W] ? (CNT_W+1)'(0) - v : v;
  endfunction

  // saturating reduction to a correction amount
  function automatic logic [2:0] corr_amt(input logic [CNT_W:0] v);
    corr_amt = (v > (CNT_W+1)'(7)) ? 3'h7 : v[2:0];
  endfunction

  logic [TARGET_W-1:0] target_q;
  logic                lock_en_q;
  logic                wide_q;
  logic                fall_sel_q;
  logic                arm_q;
  logic                flush_q;
  logic                pulse_lock_q;
  logic                rate_lock_q;
  logic [CNT_W-1:0]    last_cnt_q;
  logic [CNT_W-1:0]    samp_cnt_q;
  logic [CYC_W-1:0]    cyc_q;
  logic [2:0]          drop_q;
  logic [2:0]          rep_q;
  logic                ready_q;
  logic [DATA_W-1:0]   rdata_q;
  apr_lock_t           lock_q;
  apr_trig_t           trig_q;

  logic                pps_edge;
  logic                ext_edge;
  logic                wr_brd;
  logic                wr_pps;
  logic                arm_set;
  logic                flush_wr;
  logic                sw_sync;
  logic                lock_start;
  logic                lock_active;
  logic                trig_ev;
  logic                trig_done;
  logic                period_ok;
  logic                timeout;
  logic                acq_en;
  logic [2:0]          corr_max;
  logic signed [CNT_W:0] err;
  logic [CNT_W:0]      err_mag;

  // reference and trigger share the external timing pin
  apr_pin_edge #(.MIN_HIGH(1)) u_pps_edge
  (
    .clk_in    (CLK_IN),
    .rst_b_in  (RST_B_IN),
    .pin_in    (EXTERNAL_TIMING_INPUT_IN),
    .invert_in (fall_sel_q),
    .edge_out  (pps_edge)
  );

  apr_pin_edge #(.MIN_HIGH(TRIG_MIN_HIGH_CYC)) u_trig_edge
  (
    .clk_in    (CLK_IN),
    .rst_b_in  (RST_B_IN),
    .pin_in    (EXTERNAL_TIMING_INPUT_IN),
    .invert_in (1'b0),
    .edge_out  (ext_edge)
  );

  assign wr_brd   = REG_WR_IN && (REG_ADDR_IN == BRD_CTRL_ADDR);
  assign wr_pps   = REG_WR_IN && (REG_ADDR_IN == PPS_CTRL_ADDR);
  assign flush_wr = wr_brd && REG_WDATA_IN[FLUSH_BIT];
  assign arm_set  = wr_brd && REG_WDATA_IN[ARM_BIT] && !REG_WDATA_IN[FLUSH_BIT];
  assign sw_sync  = wr_brd && REG_WDATA_IN[SW_SYNC_BIT];

  // arm holds the reference lock off; it restarts after the trigger completes
  assign lock_active = lock_en_q && !arm_q;
  assign lock_start  = wr_pps && REG_WDATA_IN[LOCK_EN_BIT] && !lock_en_q;

  // pin trigger only counts while the pin is not serving as the reference
  assign trig_ev   = sw_sync || (ext_edge && !lock_en_q);
  assign trig_done = (trig_q == T_WAIT) && SCAN_SET_IN;

  assign period_ok = (cyc_q >= PER_MIN) && (cyc_q <= PER_MAX);
  assign timeout   = (cyc_q > PER_MAX);
  assign corr_max  = wide_q ? CORR_WIDE : CORR_NARROW;
  assign err       = $signed({1'b0, samp_cnt_q}) - $signed({2'b00, target_q});
  assign err_mag   = abs_err(err);

  assign acq_en = ((trig_q == T_IDLE) || trig_done)
                  && !lock_start && !arm_set && !(sw_sync && flush_q)
                  && (!lock_active || lock_q == L_RUN);

  // lock control register
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      target_q   <= TARGET_RST;
      lock_en_q  <= 1'b0;
      wide_q     <= 1'b0;
      fall_sel_q <= 1'b0;
    end
    else if (wr_pps)
    begin
      target_q   <= REG_WDATA_IN[TARGET_LSB +: TARGET_W];
      lock_en_q  <= REG_WDATA_IN[LOCK_EN_BIT];
      wide_q     <= REG_WDATA_IN[WIDE_BIT];
      fall_sel_q <= REG_WDATA_IN[FALL_SEL_BIT];
    end
  end

  // arm bit: a software set beats the self-clear, a flush write beats both
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      arm_q   <= 1'b0;
      flush_q <= 1'b0;
    end
    else
    begin
      if (wr_brd)
        flush_q <= REG_WDATA_IN[FLUSH_BIT];
      if (flush_wr)
        arm_q <= 1'b0;
      else if (arm_set)
        arm_q <= 1'b1;
      else if (trig_done)
        arm_q <= 1'b0;
    end
  end

  // trigger sequence
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      trig_q <= T_IDLE;
    else if (flush_wr)
      trig_q <= T_IDLE;
    else if (arm_set)
      trig_q <= T_ARMED;
    else
    begin
      unique case (trig_q)
        T_IDLE:
          trig_q <= T_IDLE;
        T_ARMED:
          if (trig_ev)
            trig_q <= T_WAIT;
        T_WAIT:
          if (SCAN_SET_IN)
            trig_q <= T_IDLE;
        default:
          trig_q <= T_IDLE;
      endcase
    end
  end

  // second boundaries: counters restart at each selected reference edge
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      cyc_q      <= '0;
      samp_cnt_q <= '0;
      last_cnt_q <= '0;
    end
    else if (!lock_active || lock_start)
    begin
      cyc_q      <= '0;
      samp_cnt_q <= '0;
    end
    else if (pps_edge)
    begin
      cyc_q      <= '0;
      samp_cnt_q <= SCAN_SET_IN ? CNT_W'(1) : '0;
      last_cnt_q <= samp_cnt_q;
    end
    else
    begin
      if (!timeout)
        cyc_q <= cyc_q + CYC_W'(1);
      if (SCAN_SET_IN && samp_cnt_q != '1)
        samp_cnt_q <= samp_cnt_q + CNT_W'(1);
    end
  end

  // locking sequence and lock flags
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      lock_q       <= L_OFF;
      pulse_lock_q <= 1'b0;
      rate_lock_q  <= 1'b0;
    end
    else if (!lock_active)
    begin
      lock_q       <= L_OFF;
      pulse_lock_q <= 1'b0;
      rate_lock_q  <= 1'b0;
    end
    else if (lock_start)
    begin
      lock_q       <= L_SEEK;
      pulse_lock_q <= 1'b0;
      rate_lock_q  <= 1'b0;
    end
    else
    begin
      unique case (lock_q)
        L_OFF:
          lock_q <= L_SEEK;
        L_SEEK:
          if (pps_edge)
            lock_q <= L_MEAS;
        L_MEAS:
          if (timeout)
          begin
            lock_q       <= L_SEEK;
            pulse_lock_q <= 1'b0;
            rate_lock_q  <= 1'b0;
          end
          else if (pps_edge)
          begin
            pulse_lock_q <= period_ok;
            rate_lock_q  <= (err == '0);
            if (period_ok && err == '0)
              lock_q <= L_RUN;
          end
        L_RUN:
          if (timeout || (pps_edge && (!period_ok || err_mag > 4'(corr_max))))
          begin
            lock_q       <= L_SEEK;
            pulse_lock_q <= 1'b0;
            rate_lock_q  <= 1'b0;
          end
      endcase
    end
  end

  // pending corrections, consumed one per sample set
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      drop_q <= '0;
      rep_q  <= '0;
    end
    else if (lock_q != L_RUN || !lock_active)
    begin
      drop_q <= '0;
      rep_q  <= '0;
    end
    else if (pps_edge && period_ok && err_mag <= 4'(corr_max))
    begin
      drop_q <= err[CNT_W] ? 3'h0 : corr_amt(err_mag);
      rep_q  <= err[CNT_W] ? corr_amt(err_mag) : 3'h0;
    end
    else if (SCAN_SET_IN)
    begin
      if (drop_q != '0)
        drop_q <= drop_q - 3'h1;
      else if (rep_q != '0)
        rep_q <= rep_q - 3'h1;
    end
  end

  // sample set gating toward the buffer
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      STORE_SET_OUT  <= 1'b0;
      REPEAT_SET_OUT <= 1'b0;
    end
    else
    begin
      STORE_SET_OUT  <= SCAN_SET_IN && acq_en && (drop_q == '0);
      REPEAT_SET_OUT <= SCAN_SET_IN && acq_en && (drop_q == '0)
                        && (rep_q != '0);
    end
  end

  // buffer clear: held through arm and trigger wait, pulsed at lock start
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      BUF_CLEAR_OUT <= 1'b0;
    else
      BUF_CLEAR_OUT <= lock_start || arm_set
                       || (trig_q == T_ARMED)
                       || ((trig_q == T_WAIT) && !SCAN_SET_IN)
                       || (sw_sync && flush_q);
  end

  // ready rises once both the trigger sequence and the lock sequence are done
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      ready_q <= 1'b0;
    else
      ready_q <= (trig_q == T_IDLE || trig_done) && !arm_set
                 && (!lock_active || lock_q == L_RUN);
  end

  // register read, data valid in the cycle after the strobe only
  always_ff @(posedge CLK_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      rdata_q <= '0;
    else if (!REG_RD_IN)
      rdata_q <= '0;
    else
    begin
      rdata_q <= '0;
      unique case (REG_ADDR_IN)
        BRD_CTRL_ADDR:
        begin
          rdata_q[ARM_BIT]       <= arm_q;
          rdata_q[FLUSH_BIT]     <= flush_q;
          rdata_q[ACQ_READY_BIT] <= ready_q;
        end
        PPS_CTRL_ADDR:
        begin
          rdata_q[TARGET_LSB +: TARGET_W] <= target_q;
          rdata_q[LOCK_EN_BIT]            <= lock_en_q;
          rdata_q[WIDE_BIT]               <= wide_q;
          rdata_q[FALL_SEL_BIT]           <= fall_sel_q;
          rdata_q[PULSE_LOCK_BIT]         <= pulse_lock_q;
          rdata_q[RATE_LOCK_BIT]          <= rate_lock_q;
        end
        PPS_STAT_ADDR:
          rdata_q[CNT_W-1:0] <= last_cnt_q;
        default:
          rdata_q <= '0;
      endcase
    end
  end

  assign REG_RDATA_OUT    = rdata_q;
  assign ACQ_READY_OUT    = ready_q;
  assign PULSE_LOCKED_OUT = pulse_lock_q;
  assign RATE_LOCKED_OUT  = rate_lock_q;

endmodule
`default_nettype wire

// file: sim/apr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module apr_monitor
  import apr_pkg::*;
(
  input  wire logic              CLK_IN,
  input  wire logic              RST_B_IN,
  input  wire logic [ADDR_W-1:0] REG_ADDR_IN,
  input  wire logic              REG_RD_IN,
  input  wire logic [DATA_W-1:0] REG_RDATA_OUT,
  input  wire logic              SCAN_SET_IN,
  input  wire logic              STORE_SET_OUT,
  input  wire logic              REPEAT_SET_OUT,
  input  wire logic              BUF_CLEAR_OUT,
  input  wire logic              ACQ_READY_OUT,
  input  wire logic              PULSE_LOCKED_OUT,
  input  wire logic              RATE_LOCKED_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  property p_store_after_scan;
    STORE_SET_OUT |-> $past(SCAN_SET_IN);
  endproperty
  a_store_after_scan: assert property (p_store_after_scan)
    else $error("store pulse without a scan the cycle before");

  property p_repeat_with_store;
    REPEAT_SET_OUT |-> STORE_SET_OUT;
  endproperty
  a_repeat_with_store: assert property (p_repeat_with_store)
    else $error("duplicate set without its stored set");

  property p_no_store_in_clear;
    BUF_CLEAR_OUT |-> !STORE_SET_OUT;
  endproperty
  a_no_store_in_clear: assert property (p_no_store_in_clear)
    else $error("set stored while buffer held clear");

  // first store after a held buffer must also release it and flag ready
  property p_first_store;
    STORE_SET_OUT && $past(BUF_CLEAR_OUT) |-> ACQ_READY_OUT && !BUF_CLEAR_OUT;
  endproperty
  a_first_store: assert property (p_first_store)
    else $error("first stored scan without ready rising");

  property p_repeat_needs_lock;
    REPEAT_SET_OUT |-> RATE_LOCKED_OUT && PULSE_LOCKED_OUT;
  endproperty
  a_repeat_needs_lock: assert property (p_repeat_needs_lock)
    else $error("correction while not locked");

  property p_flags_off_armed;
    BUF_CLEAR_OUT [*2] |-> !PULSE_LOCKED_OUT && !RATE_LOCKED_OUT;
  endproperty
  a_flags_off_armed: assert property (p_flags_off_armed)
    else $error("lock flags set while buffer held");

  property p_ready_low_held;
    BUF_CLEAR_OUT [*2] |-> !ACQ_READY_OUT;
  endproperty
  a_ready_low_held: assert property (p_ready_low_held)
    else $error("ready high while buffer held");

  property p_rd_flags;
    REG_RD_IN && REG_ADDR_IN == PPS_CTRL_ADDR |=>
      REG_RDATA_OUT[RATE_LOCK_BIT:PULSE_LOCK_BIT] == $past({RATE_LOCKED_OUT, PULSE_LOCKED_OUT});
  endproperty
  a_rd_flags: assert property (p_rd_flags)
    else $error("lock flags read back differ from outputs");
endmodule

bind apr_ctrl apr_monitor u_monitor (.CLK_IN(CLK_IN), .RST_B_IN(RST_B_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .SCAN_SET_IN(SCAN_SET_IN), .STORE_SET_OUT(STORE_SET_OUT), .REPEAT_SET_OUT(REPEAT_SET_OUT),
  .BUF_CLEAR_OUT(BUF_CLEAR_OUT), .ACQ_READY_OUT(ACQ_READY_OUT),
  .PULSE_LOCKED_OUT(PULSE_LOCKED_OUT), .RATE_LOCKED_OUT(RATE_LOCKED_OUT));
`default_nettype wire

// file: sim/apr_pps_src.sv
`timescale 1ns/1ps
`default_nettype none
module apr_pps_src
#(
  parameter int unsigned PERIOD = 200,
  parameter int unsigned WIDTH  = 20
)
(
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       pps_on_in,
  input  wire logic       trig_go_in,
  input  wire logic [7:0] trig_len_in,
  output logic            pin_out
);
  int unsigned pps_cnt_q;
  logic [7:0]  trig_cnt_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pps_cnt_q <= 0;
    else if (!pps_on_in || pps_cnt_q == PERIOD - 1)
      pps_cnt_q <= 0;
    else
      pps_cnt_q <= pps_cnt_q + 1;
  end

  // short lengths model a source too brief to be accepted
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      trig_cnt_q <= 8'h00;
    else if (trig_go_in)
      trig_cnt_q <= trig_len_in;
    else if (trig_cnt_q != 8'h00)
      trig_cnt_q <= trig_cnt_q - 8'h01;
  end

  // pin idles low; pulses rise on exact period so each second has the same scan count
  assign pin_out = (pps_on_in && pps_cnt_q < WIDTH) || (trig_cnt_q != 8'h00);
endmodule
`default_nettype wire

// file: sim/apr_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module apr_ctrl_bench
  import apr_pkg::*;
;
  logic              clk, rst_b, wr, rd, scan, pps_on, trig_go;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [3:0]        scan_cnt;
  logic [7:0]        trig_len;
  wire  [DATA_W-1:0] rdata;
  wire               pin, store, rep, bclr, ready, plock, rlock;
  int                n_fail, check_count, n_st, n_rp, n_sc;

  apr_ctrl #(.ONE_SEC_CYC(200), .TOL_CYC(10)) DUT (.CLK_IN(clk), .RST_B_IN(rst_b),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_RDATA_OUT(rdata), .EXTERNAL_TIMING_INPUT_IN(pin), .SCAN_SET_IN(scan),
    .STORE_SET_OUT(store), .REPEAT_SET_OUT(rep), .BUF_CLEAR_OUT(bclr),
    .ACQ_READY_OUT(ready), .PULSE_LOCKED_OUT(plock), .RATE_LOCKED_OUT(rlock));
  apr_pps_src #(.PERIOD(200), .WIDTH(20)) u_src (.clk_in(clk), .rst_b_in(rst_b),
    .pps_on_in(pps_on), .trig_go_in(trig_go), .trig_len_in(trig_len), .pin_out(pin));

  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // one scan every 10 cycles: exactly 20 scans per 200-cycle second
  always @(posedge clk)
  begin
    scan_cnt <= (scan_cnt == 4'h9) ? 4'h0 : scan_cnt + 4'h1;
    scan     <= (scan_cnt == 4'h9);
    n_st += (store === 1'h1);
    n_rp += (rep === 1'h1);
    n_sc += (scan === 1'h1);
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_bit(input int idx, input logic lvl, input int lim);
    int         i;
    logic [3:0] v;
    v = {pin, rlock, plock, store};
    for (i = 0; i < lim && v[idx] !== lvl; i++)
    begin
      @(posedge clk);
      #1;
      v = {pin, rlock, plock, store};
    end
    if (v[idx] !== lvl)
    begin
      n_fail++;
      $display("[ERR] wait on bit %0d expected %b seen timeout", idx, lvl);
      print_verdict();
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'h1;
    @(posedge clk);
    wr    <= 1'h0;
    #1;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'h1;
    @(posedge clk);
    rd   <= 1'h0;
    #1;
    d = rdata;
  endtask

  task automatic fire(input logic [7:0] n);
    @(posedge clk);
    trig_len <= n;
    trig_go  <= 1'h1;
    @(posedge clk);
    trig_go  <= 1'h0;
  endtask

  task automatic measure(output int st, output int rp, output int sc);
    wait_bit(3, 1'h0, 250);
    wait_bit(3, 1'h1, 250);
    repeat (100) @(posedge clk);
    #1;
    st = n_st;
    rp = n_rp;
    sc = n_sc;
    repeat (200) @(posedge clk);
    #1;
    st = n_st - st;
    rp = n_rp - rp;
    sc = n_sc - sc;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    reg_rd(PPS_CTRL_ADDR, d);
    check("lock ctrl", d, 32'h00002000);
    reg_rd(BRD_CTRL_ADDR, d);
    check("board ctrl", d, 32'h00000008);
    reg_rd(8'h40, d);
    check("unmapped", d, 32'h00000000);
    $display("test reset done");
  endtask

  task automatic t_triggers();
    logic [31:0] d;
    reg_wr(BRD_CTRL_ADDR, 32'h00000001);
    repeat (30) @(posedge clk);
    #1;
    check("armed hold", {30'h0, bclr, ready}, 32'h2);
    reg_wr(BRD_CTRL_ADDR, 32'h00000002);
    wait_bit(0, 1'h1, 40);
    check("sw trigger", {30'h0, bclr, ready}, 32'h1);
    reg_rd(BRD_CTRL_ADDR, d);
    check("arm self clear", d, 32'h00000008);
    reg_wr(BRD_CTRL_ADDR, 32'h00000002);
    repeat (30) @(posedge clk);
    #1;
    check("late sync", {30'h0, bclr, ready}, 32'h1);
    reg_wr(BRD_CTRL_ADDR, 32'h00000001);
    fire(8'h02);
    repeat (40) @(posedge clk);
    #1;
    check("short pulse", {30'h0, bclr, ready}, 32'h2);
    fire(8'h05);
    wait_bit(0, 1'h1, 60);
    check("pin trigger", {30'h0, bclr, ready}, 32'h1);
    reg_wr(BRD_CTRL_ADDR, 32'h00000001);
    reg_wr(BRD_CTRL_ADDR, 32'h00000004);
    reg_rd(BRD_CTRL_ADDR, d);
    check("flush clears arm", d, 32'h0000000C);
    reg_wr(BRD_CTRL_ADDR, 32'h00000005);
    reg_rd(BRD_CTRL_ADDR, d);
    check("flush wins", d, 32'h0000000C);
    reg_wr(BRD_CTRL_ADDR, 32'h00000000);
    $display("test triggers done");
  endtask

  task automatic t_lock();
    logic [31:0] d;
    int          st, rp, sc;
    @(posedge clk);
    pps_on <= 1'h1;
    #1;
    check("ready first", {31'h0, ready}, 32'h1);
    reg_wr(PPS_CTRL_ADDR, 32'h00100014);
    wait_bit(2, 1'h1, 1000);
    check("pulse lock", {31'h0, plock}, 32'h1);
    measure(st, rp, sc);
    check("even stores", 32'(sc - st), 32'h0);
    check("even repeats", 32'(rp), 32'h0);
    reg_rd(PPS_STAT_ADDR, d);
    check("count", d, 32'h00000014);
    reg_wr(PPS_CTRL_ADDR, 32'h00100013);
    measure(st, rp, sc);
    check("one drop", 32'(sc - st), 32'h1);
    reg_wr(PPS_CTRL_ADDR, 32'h00100015);
    measure(st, rp, sc);
    check("one repeat", 32'(rp), 32'h1);
    // wide mode, as advised for fast rates
    reg_wr(PPS_CTRL_ADDR, 32'h00300017);
    measure(st, rp, sc);
    check("wide repeats", 32'(rp), 32'h3);
    check("wide lock", {31'h0, rlock}, 32'h1);
    reg_wr(PPS_CTRL_ADDR, 32'h00100019);
    wait_bit(2, 1'h0, 300);
    measure(st, rp, sc);
    check("halted", 32'(st), 32'h0);
    check("not ready", {31'h0, ready}, 32'h0);
    reg_wr(PPS_CTRL_ADDR, 32'h00100014);
    wait_bit(2, 1'h1, 1000);
    reg_wr(PPS_CTRL_ADDR, 32'h00500014);
    wait_bit(2, 1'h0, 300);
    wait_bit(2, 1'h1, 1000);
    check("falling lock", {30'h0, plock, rlock}, 32'h3);
    reg_wr(BRD_CTRL_ADDR, 32'h00000001);
    repeat (3) @(posedge clk);
    #1;
    check("armed unlocks", {30'h0, plock, rlock}, 32'h0);
    $display("test lock done");
  endtask

  initial
  begin
    {rst_b, wr, rd, pps_on, trig_go} = 5'h00;
    {addr, wdata, trig_len, scan_cnt, scan} = '0;
    {n_fail, check_count, n_st, n_rp, n_sc} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    #1;
    t_reset();
    t_triggers();
    t_lock();
    print_verdict();
  end
endmodule
`default_nettype wire
